/* src/cos_pkg.sv */
// constants and types shared by the contact output and trip supervision block
package cos_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned MS_CYCLES_DFLT = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned MS_W = 16;
  localparam int unsigned CONT_FAIL_MS = 500;
  localparam int unsigned CONT_W = 10;
  localparam logic [CONT_W-1:0] CONT_LIMIT = CONT_W'(CONT_FAIL_MS);
  localparam int unsigned PULSE_W = 16;
  localparam logic [PULSE_W-1:0] PULSE_DFLT_MS = PULSE_W'(10000);

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned N_OUT = 8;
  localparam int unsigned N_BOARD = 4;
  localparam int unsigned N_CIRC = 2;
  localparam int unsigned N_EV = 8;
  localparam int unsigned SEAL_OUT_A = 6;
  localparam int unsigned SEAL_OUT_B = 7;

  // ----------------------------------------------------------------
  // register map (byte offsets) and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TYPE = 8'h00;
  localparam logic [7:0] ADDR_POL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_PULSE0 = 8'h20;
  localparam logic [7:0] ADDR_PULSE_LAST = 8'h3C;
  localparam int unsigned STAT_ACT = 0;
  localparam int unsigned STAT_OPND = 8;
  localparam int unsigned STAT_BRD = 16;
  localparam int unsigned EV_CONT = 0;
  localparam int unsigned EV_SEAL = 2;
  localparam int unsigned EV_BRD = 4;
  localparam logic [15:0] TYPE_RST = 16'h0000;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {COS_NORMAL, COS_PULSE, COS_LATCHED} cos_otype_e;

endpackage

/* src/cos_chan_if.sv */
// signals between the block top and one contact output channel
`timescale 1ns/100ps
`default_nettype none
interface cos_chan_if;
  import cos_pkg::*;
  logic cmd;
  logic clear;
  logic [1:0] otype;
  logic invert;
  logic [PULSE_W-1:0] pulse_ms;
  logic ms_tick;
  logic seal;
  logic active;
  logic phys;
  modport chan (input cmd, clear, otype, invert, pulse_ms, ms_tick, seal, output active, phys);
  modport top (output cmd, clear, otype, invert, pulse_ms, ms_tick, seal, input active, phys);
endinterface
`default_nettype wire

/* src/cos_out_chan.sv */
// one contact output: normal, pulse or latched shaping, seal-in and polarity
`timescale 1ns/100ps
`default_nettype none
module cos_out_chan
  import cos_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  cos_chan_if.chan ch
);

  logic latch;
  logic next_latch;
  logic [PULSE_W-1:0] pcnt;
  logic [PULSE_W-1:0] next_pcnt;
  logic next_active;
  logic next_phys;
  logic logic_on;

  always_comb begin
    next_latch = latch;
    next_pcnt = pcnt;
    logic_on = ch.cmd;
    case (ch.otype)
      COS_PULSE: begin
        // hold for the command time plus the pulse length
        if (ch.cmd) begin
          next_pcnt = ch.pulse_ms;
        end else if (ch.ms_tick && pcnt != '0) begin
          next_pcnt = pcnt - PULSE_W'(1);
        end
        logic_on = ch.cmd | (pcnt != '0);
      end
      COS_LATCHED: begin
        // a command in the same cycle as the clear keeps the latch set
        if (ch.clear) begin
          next_latch = 1'b0;
        end
        if (ch.cmd) begin
          next_latch = 1'b1;
        end
        logic_on = ch.cmd | next_latch;
      end
      default: begin
        next_latch = 1'b0;
        next_pcnt = '0;
        logic_on = ch.cmd;
      end
    endcase
    // current through the contact keeps it closed whatever the command
    next_active = logic_on | (ch.active & ch.seal);
    next_phys = next_active ^ ch.invert;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch <= 1'b0;
      pcnt <= '0;
      ch.active <= 1'b0;
      ch.phys <= 1'b0;
    end else begin
      latch <= next_latch;
      pcnt <= next_pcnt;
      ch.active <= next_active;
      ch.phys <= next_phys;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_normal;
    (ch.otype == COS_NORMAL && !ch.seal) |=> (ch.active == $past(ch.cmd));
  endproperty
  a_normal: assert property (p_normal) else $error("normal output not following command");

  property p_latch_hold;
    (ch.otype == COS_LATCHED && ch.active && !ch.clear) ##1 (ch.otype == COS_LATCHED && !ch.clear)
      |-> ch.active;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched output dropped");

  property p_latch_clear;
    (ch.otype == COS_LATCHED && ch.clear && !ch.cmd && !ch.seal) |=> !ch.active;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_seal;
    (ch.active && ch.seal) |=> ch.active;
  endproperty
  a_seal: assert property (p_seal) else $error("sealed output opened");

  property p_seal_open;
    $fell(ch.active) |-> !$past(ch.seal);
  endproperty
  a_seal_open: assert property (p_seal_open) else $error("output opened under current");

  property p_pol;
    ##1 (ch.phys == (ch.active ^ $past(ch.invert)));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong");

  property p_pulse;
    (ch.otype == COS_PULSE && ch.cmd && ch.pulse_ms != '0) ##1 (ch.otype == COS_PULSE)
      |-> ch.active ##1 (ch.otype != COS_PULSE || ch.active);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse output too short");

  c_seal: cover property (ch.active && ch.seal && !ch.cmd);
  c_pulse_end: cover property (ch.otype == COS_PULSE && $fell(ch.active));

endmodule // cos_out_chan
`default_nettype wire

/* src/cos_top.sv */
// contact outputs, board status and trip circuit supervision with AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
module cos_top
  import cos_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [N_OUT-1:0] output_operate_cmd_n,
  input wire logic [N_OUT-1:0] output_latch_clear_n,
  input wire logic circuit1_detector_a,
  input wire logic circuit1_detector_b,
  input wire logic circuit2_detector_a,
  input wire logic circuit2_detector_b,
  input wire logic output7_current_sense,
  input wire logic output8_current_sense,
  input wire logic [N_BOARD-1:0] board_anomaly,
  input wire logic [N_BOARD-1:0] board_absent,
  output logic [N_OUT-1:0] output_status_n,
  output logic [N_OUT-1:0] output_drive,
  output logic circuit1_continuity_ok,
  output logic circuit2_continuity_ok,
  output logic [7:0] supervision_operands,
  output logic [N_BOARD-1:0] board_status,
  output logic irq
);

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  logic [MS_W-1:0] ms_cnt;
  logic [MS_W-1:0] next_ms_cnt;
  logic ms_tick;

  always_comb begin
    ms_tick = (ms_cnt == MS_W'(MS_CYCLES - 1));
    next_ms_cnt = ms_tick ? '0 : ms_cnt + MS_W'(1);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= next_ms_cnt;
    end
  end

  // ----------------------------------------------------------------
  // supervision: continuity timers and operands
  // ----------------------------------------------------------------
  logic [1:0] det_a;
  logic [1:0] det_b;
  logic [1:0] sense;
  logic [N_CIRC-1:0] cont_ok;
  logic [N_CIRC-1:0] next_cont_ok;
  logic [CONT_W-1:0] cont_cnt [N_CIRC];
  logic [CONT_W-1:0] next_cont_cnt [N_CIRC];
  logic [7:0] next_operands;
  logic [N_BOARD-1:0] next_board_status;

  // circuit 1 on index 0, circuit 2 on index 1
  assign det_a = {circuit2_detector_a, circuit1_detector_a};
  assign det_b = {circuit2_detector_b, circuit1_detector_b};
  assign sense = {output8_current_sense, output7_current_sense};

  // no enable anywhere: these run from reset release onward
  always_comb begin
    for (int i = 0; i < N_CIRC; i++) begin
      next_cont_cnt[i] = cont_cnt[i];
      if (det_a[i] | det_b[i]) begin
        next_cont_cnt[i] = '0;
      end else if (ms_tick && cont_cnt[i] <= CONT_LIMIT) begin
        next_cont_cnt[i] = cont_cnt[i] + CONT_W'(1);
      end
      // only the detectors and the timer decide, nothing else
      next_cont_ok[i] = (next_cont_cnt[i] <= CONT_LIMIT);
    end
    next_operands = {next_cont_ok, sense, det_b[1], det_a[1], det_b[0], det_a[0]};
    next_board_status = board_anomaly | board_absent;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N_CIRC; i++) begin
        cont_cnt[i] <= '0;
      end
      cont_ok <= '1;
      // continuity operands mirror the flags, which come out of reset high
      supervision_operands[7:6] <= '1;
      supervision_operands[5:0] <= '0;
      board_status <= '0;
    end else begin
      for (int i = 0; i < N_CIRC; i++) begin
        cont_cnt[i] <= next_cont_cnt[i];
      end
      cont_ok <= next_cont_ok;
      supervision_operands <= next_operands;
      board_status <= next_board_status;
    end
  end

  assign circuit1_continuity_ok = cont_ok[0];
  assign circuit2_continuity_ok = cont_ok[1];

  // ----------------------------------------------------------------
  // AHB-Lite slave and register file
  // ----------------------------------------------------------------
  logic [15:0] type_reg;
  logic [15:0] next_type_reg;
  logic [N_OUT-1:0] pol_reg;
  logic [N_OUT-1:0] next_pol_reg;
  logic [PULSE_W-1:0] pulse_reg [N_OUT];
  logic [PULSE_W-1:0] next_pulse_reg [N_OUT];
  logic [N_EV-1:0] irq_stat;
  logic [N_EV-1:0] next_irq_stat;
  logic [N_EV-1:0] irq_mask;
  logic [N_EV-1:0] next_irq_mask;
  logic [N_EV-1:0] events;
  logic [1:0] sense_q;
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic addr_phase;
  logic wr_go;
  logic [N_OUT-1:0] act;
  logic [2:0] pidx;

  assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == 2'h3);
  assign wr_go = wr_pend;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // events: continuity lost, seal current appears, board flag rises
  assign events = {~board_status & next_board_status, sense & ~sense_q,
                   cont_ok & ~next_cont_ok};

  always_comb begin
    next_wr_pend = addr_phase & hwrite;
    next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
    next_type_reg = type_reg;
    next_pol_reg = pol_reg;
    next_irq_mask = irq_mask;
    for (int i = 0; i < N_OUT; i++) begin
      next_pulse_reg[i] = pulse_reg[i];
    end
    next_irq_stat = irq_stat;
    pidx = wr_addr[4:2];
    if (wr_go) begin
      if (wr_addr == ADDR_TYPE) begin
        next_type_reg = hwdata[15:0];
      end else if (wr_addr == ADDR_POL) begin
        next_pol_reg = hwdata[N_OUT-1:0];
      end else if (wr_addr == ADDR_IRQ) begin
        next_irq_stat = irq_stat & ~hwdata[N_EV-1:0];
      end else if (wr_addr == ADDR_MASK) begin
        next_irq_mask = hwdata[N_EV-1:0];
      end else if (wr_addr >= ADDR_PULSE0 && wr_addr <= ADDR_PULSE_LAST
                   && wr_addr[1:0] == 2'h0) begin
        next_pulse_reg[pidx] = hwdata[PULSE_W-1:0];
      end
    end
    // a new event beats a clear in the same cycle
    next_irq_stat = next_irq_stat | events;
    next_hrdata = hrdata;
    if (addr_phase && !hwrite) begin
      if (haddr[7:0] == ADDR_TYPE) begin
        next_hrdata = {16'h0000, type_reg};
      end else if (haddr[7:0] == ADDR_POL) begin
        next_hrdata = {24'h000000, pol_reg};
      end else if (haddr[7:0] == ADDR_STAT) begin
        next_hrdata = {12'h000, board_status, supervision_operands, act};
      end else if (haddr[7:0] == ADDR_IRQ) begin
        next_hrdata = {24'h000000, irq_stat};
      end else if (haddr[7:0] == ADDR_MASK) begin
        next_hrdata = {24'h000000, irq_mask};
      end else if (haddr[7:0] >= ADDR_PULSE0 && haddr[7:0] <= ADDR_PULSE_LAST
                   && haddr[1:0] == 2'h0) begin
        next_hrdata = {16'h0000, pulse_reg[haddr[4:2]]};
      end else begin
        next_hrdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      type_reg <= TYPE_RST;
      pol_reg <= POL_RST;
      for (int i = 0; i < N_OUT; i++) begin
        pulse_reg[i] <= PULSE_DFLT_MS;
      end
      irq_stat <= '0;
      irq_mask <= '0;
      sense_q <= '0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      type_reg <= next_type_reg;
      pol_reg <= next_pol_reg;
      for (int i = 0; i < N_OUT; i++) begin
        pulse_reg[i] <= next_pulse_reg[i];
      end
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      sense_q <= sense;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      irq <= |(next_irq_stat & next_irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // contact output channels
  // ----------------------------------------------------------------
  cos_chan_if ch [N_OUT] ();

  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    assign ch[g].cmd = output_operate_cmd_n[g];
    assign ch[g].clear = output_latch_clear_n[g];
    assign ch[g].otype = type_reg[2*g+1:2*g];
    assign ch[g].invert = pol_reg[g];
    assign ch[g].pulse_ms = pulse_reg[g];
    assign ch[g].ms_tick = ms_tick;
    // only the two current sensing outputs can seal
    if (g == SEAL_OUT_A) begin : g_seal_a
      assign ch[g].seal = sense[0];
    end else if (g == SEAL_OUT_B) begin : g_seal_b
      assign ch[g].seal = sense[1];
    end else begin : g_noseal
      assign ch[g].seal = 1'b0;
    end
    assign act[g] = ch[g].active;
    assign output_status_n[g] = ch[g].active;
    assign output_drive[g] = ch[g].phys;
    cos_out_chan u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .ch(ch[g])
    );
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_cont_fail;
    $fell(circuit1_continuity_ok) |-> ($past(det_a[0] | det_b[0]) == 1'b0 && cont_cnt[0] > CONT_LIMIT);
  endproperty
  a_cont_fail: assert property (p_cont_fail) else $error("circuit 1 failed early");

  property p_cont_back;
    (det_a[1] | det_b[1]) |=> (circuit2_continuity_ok && cont_cnt[1] == '0);
  endproperty
  a_cont_back: assert property (p_cont_back) else $error("circuit 2 not restored");

  property p_cont_only;
    circuit2_continuity_ok == (cont_cnt[1] <= CONT_LIMIT);
  endproperty
  a_cont_only: assert property (p_cont_only) else $error("continuity flag off its timer");

  property p_volt_flags;
    ##1 supervision_operands[3:0] == $past({det_b[1], det_a[1], det_b[0], det_a[0]});
  endproperty
  a_volt_flags: assert property (p_volt_flags) else $error("voltage operands wrong");

  property p_sense_flags;
    ##1 supervision_operands[5:4] == $past(sense);
  endproperty
  a_sense_flags: assert property (p_sense_flags) else $error("current operands wrong");

  property p_cont_flags;
    supervision_operands[7:6] == {circuit2_continuity_ok, circuit1_continuity_ok};
  endproperty
  a_cont_flags: assert property (p_cont_flags) else $error("continuity operands wrong");

  property p_board;
    ##1 board_status == $past(board_anomaly | board_absent);
  endproperty
  a_board: assert property (p_board) else $error("board status wrong");

  property p_seal7;
    (output_status_n[SEAL_OUT_A] && output7_current_sense) |=> output_status_n[SEAL_OUT_A];
  endproperty
  a_seal7: assert property (p_seal7) else $error("output 7 opened under current");

  c_cont_fail: cover property ($fell(circuit1_continuity_ok));
  c_irq: cover property ($rose(irq));
  c_cont_back: cover property ($rose(circuit2_continuity_ok));

endmodule // cos_top
`default_nettype wire

/* bench/cos_trip_model.sv */
// breaker trip circuit model: voltage detectors and seal current sensors
`timescale 1ns/100ps
`default_nettype none
module cos_trip_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] trip_closed,
  input wire logic [1:0] healthy,
  input wire logic [1:0] aux_closed,
  output logic c1a,
  output logic c1b,
  output logic c2a,
  output logic c2b,
  output logic s7,
  output logic s8
);
  // a closed trip contact shorts both detectors of its circuit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {c1a, c1b, c2a, c2b, s7, s8} <= 6'h00;
    end else begin
      {c1a, c1b} <= {2{healthy[0] & !trip_closed[0]}};
      {c2a, c2b} <= {2{healthy[1] & !trip_closed[1]}};
      // current flows only while the slow auxiliary contact is still closed
      s7 <= trip_closed[0] & aux_closed[0] & healthy[0];
      s8 <= trip_closed[1] & aux_closed[1] & healthy[1];
    end
  end
endmodule // cos_trip_model
`default_nettype wire

/* bench/cos_top_tb.sv */
// self-checking testbench for the contact output and trip supervision block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module cos_top_tb;
  import cos_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, healthy = 2'h3, aux = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, ok1, ok2, irq, c1a, c1b, c2a, c2b, s7, s8;
  wire logic hready;
  logic [N_OUT-1:0] cmd = 0, clr = 0, status, drive;
  logic [N_BOARD-1:0] anom = 0, absn = 0, bstat;
  logic [7:0] opnd;
  int miscompares = 0, samples_checked = 0;
  assign hready = hreadyout;
  cos_top #(.MS_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .output_operate_cmd_n(cmd),
    .output_latch_clear_n(clr), .circuit1_detector_a(c1a), .circuit1_detector_b(c1b),
    .circuit2_detector_a(c2a), .circuit2_detector_b(c2b), .output7_current_sense(s7),
    .output8_current_sense(s8), .board_anomaly(anom), .board_absent(absn),
    .output_status_n(status), .output_drive(drive), .circuit1_continuity_ok(ok1),
    .circuit2_continuity_ok(ok2), .supervision_operands(opnd), .board_status(bstat),
    .irq(irq));
  cos_trip_model far (.hclk(hclk), .hresetn(hresetn), .trip_closed(drive[7:6]),
    .healthy(healthy), .aux_closed(aux), .c1a(c1a), .c1b(c1b), .c2a(c2a), .c2b(c2b),
    .s7(s7), .s8(s8));
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // run control and bus cycles
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_regs();
    bus(0, ADDR_TYPE, 0); `CHK(rd, {16'h0000, TYPE_RST})
    bus(0, ADDR_POL, 0); `CHK(rd, {24'h000000, POL_RST})
    bus(0, ADDR_PULSE0, 0); `CHK(rd[15:0], PULSE_DFLT_MS)
    bus(0, 8'h40, 0); `CHK(rd, 32'h00000000)
    `CHK(hresp, 1'b0)
  endtask
  task automatic t_polarity();
    bus(1, ADDR_POL, 32'h01);
    cmd[0] <= 1'b1;
    cyc(2);
    `CHK(status[0], 1'b1)
    `CHK(drive[0], 1'b0)
    cmd[0] <= 1'b0;
    cyc(2);
    `CHK(drive[0], 1'b1)
    bus(1, ADDR_POL, 32'h00);
    cyc(2);
    `CHK(drive[0], 1'b0)
  endtask
  task automatic t_pulse_latch();
    bus(1, ADDR_TYPE, 32'h24);
    bus(1, ADDR_PULSE0 + 8'h04, 32'h3);
    cmd[2:1] <= 2'h3;
    clr[2] <= 1'b1;
    cyc(3);
    `CHK(status[2:1], 2'h3)
    cmd[2:1] <= 2'h0;
    clr[2] <= 1'b0;
    cyc(8);
    `CHK(status[2:1], 2'h3)
    cyc(10);
    `CHK(status[2:1], 2'h2)
    clr[2] <= 1'b1;
    cyc(2);
    `CHK(status[2], 1'b0)
    clr[2] <= 1'b0;
  endtask
  task automatic t_board();
    bus(1, ADDR_MASK, 32'h10);
    anom <= 4'h1;
    absn <= 4'h8;
    cyc(3);
    `CHK(bstat, 4'h9)
    `CHK(irq, 1'b1)
    bus(0, ADDR_STAT, 0); `CHK(rd[19:16], 4'h9)
    bus(0, ADDR_IRQ, 0); `CHK(rd[7:4], 4'h9)
    bus(1, ADDR_IRQ, 32'hF0);
    cyc(1);
    `CHK(irq, 1'b0)
    anom <= 4'h0;
    absn <= 4'h0;
    cyc(3);
    `CHK(bstat, 4'h0)
    // a board flag that falls is not an event
    `CHK(irq, 1'b0)
  endtask
  task automatic t_operands();
    healthy <= 2'h1;
    cyc(4);
    `CHK(opnd[3:0], 4'h3)
    healthy <= 2'h3;
    cyc(4);
    `CHK(opnd[3:0], 4'hF)
    `CHK(opnd[7:6], 2'h3)
  endtask
  task automatic t_continuity();
    int n;
    bus(1, ADDR_MASK, 32'h01);
    healthy[0] <= 1'b0;
    cyc(1200);
    healthy[0] <= 1'b1;
    cyc(3);
    healthy[0] <= 1'b0;
    cyc(496 * 4);
    `CHK(ok1, 1'b1)
    `CHK(irq, 1'b0)
    n = 0;
    while (ok1 !== 1'b0 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    `CHK(ok1, 1'b0)
    if (ok1 !== 1'b0) give_verdict();
    `CHK(opnd[6], 1'b0)
    `CHK(ok2, 1'b1)
    cyc(1);
    `CHK(irq, 1'b1)
    bus(0, ADDR_IRQ, 0); `CHK(rd[1:0], 2'h1)
    healthy[0] <= 1'b1;
    cyc(4);
    `CHK(ok1, 1'b1)
    bus(1, ADDR_IRQ, 32'h01);
    cyc(1);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_seal();
    aux[0] <= 1'b1;
    cmd[6] <= 1'b1;
    cyc(5);
    `CHK(opnd[4], 1'b1)
    cmd[6] <= 1'b0;
    cyc(20);
    `CHK(status[6], 1'b1)
    `CHK(drive[6], 1'b1)
    bus(0, ADDR_IRQ, 0); `CHK(rd[3:2], 2'h1)
    aux[0] <= 1'b0;
    cyc(6);
    `CHK(status[6], 1'b0)
    `CHK(opnd[5:4], 2'h0)
    `CHK(ok1, 1'b1)
  endtask
  initial begin
    cyc(6);
    hresetn <= 1'b1;
    cyc(2);
    t_reset_regs();
    t_polarity();
    t_pulse_latch();
    t_board();
    t_operands();
    t_continuity();
    t_seal();
    give_verdict();
  end
endmodule // cos_top_tb
`default_nettype wire
